//--- pbm_pkg.sv
package pbm_pkg;

  // ---------------------------------------------------------------
  // Register indexes, seen through the MAC access/data pair
  // ---------------------------------------------------------------
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_STAT = 5'h01;
  localparam logic [4:0] IDX_ID_HI = 5'h02;
  localparam int IDX_W = 5;
  localparam int DATA_W = 16;

  // ---------------------------------------------------------------
  // Control field positions
  // ---------------------------------------------------------------
  localparam int CTRL_SRST_BIT = 15;
  localparam int CTRL_LOOP_BIT = 14;
  localparam int CTRL_SPEED_BIT = 13;
  localparam int CTRL_AN_EN_BIT = 12;
  localparam int CTRL_PDOWN_BIT = 11;
  localparam int CTRL_RESTART_BIT = 9;
  localparam int CTRL_DUPLEX_BIT = 8;
  localparam int CTRL_COLTEST_BIT = 7;

  // Writable control bits; reserved bits read zero and ignore writes
  localparam logic [15:0] CTRL_RW_MASK = 16'h7B80;
  // Control fields kept over a soft reset (none in this word)
  localparam logic [15:0] CTRL_KEEP_MASK = 16'h0000;
  // Fixed control reset value, strap bits added on top
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Status field positions and fixed ability bits
  // ---------------------------------------------------------------
  localparam int STAT_AN_DONE_BIT = 5;
  localparam int STAT_RFAULT_BIT = 4;
  localparam int STAT_LINK_BIT = 2;
  localparam int STAT_JABBER_BIT = 1;
  // T4=0, 100FD/100HD/10FD/10HD=1, AN ability=1, extended=1
  localparam logic [15:0] STAT_FIXED = 16'h7809;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int SRST_TIME_NS = 200;
  // Least time, rounded up to whole cycles
  localparam int SRST_CYCLES = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PBM_IDLE = 2'b01,
    PBM_SRST = 2'b10
  } pbm_state_t;

endpackage

//--- pbm_latch.sv
// Sticky status cell: latched high or latched low until read
module pbm_latch #(
  parameter bit LATCH_HIGH = 1'b1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic clr_i,
  input wire logic rd_i,
  input wire logic cond_i,
  // Status
  output logic val_o
);

  logic val_q;
  logic val_d;
  logic held_w;

  // Hold the sticky level; a new event joins the held value
  assign held_w = LATCH_HIGH ? (val_q | cond_i) : (val_q & cond_i);
  // A read re-samples, so an event in the read cycle is not lost
  assign val_d = clr_i ? 1'b0 : (rd_i ? cond_i : held_w);
  assign val_o = val_q;

  // State flop
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      val_q <= 1'b0;
    else
      val_q <= val_d;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_sticky_hold;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (!clr_i && !rd_i && (cond_i == LATCH_HIGH)) |=> (val_q == LATCH_HIGH);
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("sticky status lost its event");

  property p_read_resample;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (!clr_i && rd_i) |=> (val_q == $past(cond_i));
  endproperty
  a_read_resample: assert property (p_read_resample)
    else $error("sticky status did not re-sample on read");

endmodule

//--- pbm_regs.sv
// Notes on behaviour
// - Reached only through MAC access/data pair
// - Target register chosen by decimal index
// - Control bit 15 starts self-clearing soft reset
// - Kept fields survive only the soft reset
// - Control bit 14 selects loopback, resets zero
// - Bit 13 speed, ignored while negotiation enabled
// - Bit 12 enables negotiation, overriding manual bits
// - Speed and negotiation defaults follow strap pin
// - Bit 11 powers down; negotiation may follow
// - Bit 9 restarts negotiation, then self-clears
// - Bit 8 duplex, resets zero, ignored under negotiation
// - Bit 7 enables collision test, resets zero
// - T4 ability reads zero, four abilities one
// - Status bit 5 shows negotiation complete
// - Status bit 4 remote fault, latched high
// - Status bit 3 always reads one
// - Status bit 2 link, latched low
// - Status bit 1 jabber, latched high
// - Status bit 0 always reads one
// - Index 2 reads fixed identifier, read-only
module pbm_regs #(
  parameter logic [15:0] ID_HI_VALUE = 16'h1234, // Arbitrary identifier value
  parameter int SRST_LEN = pbm_pkg::SRST_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // Indirect access from the MAC access/data pair
  input wire logic acc_req_i,
  input wire logic acc_wr_i,
  input wire logic [4:0] acc_idx_i,
  input wire logic [15:0] acc_wdata_i,
  output logic acc_done_o,
  output logic [15:0] acc_rdata_o,
  // Strap and line conditions
  input wire logic speed_strap_i,
  input wire logic link_up_i,
  input wire logic remote_fault_i,
  input wire logic jabber_i,
  input wire logic an_complete_i,
  // Mode outputs to the PHY core
  output logic soft_reset_o,
  output logic loopback_o,
  output logic an_enable_o,
  output logic force_100_o,
  output logic force_full_o,
  output logic power_down_o,
  output logic an_restart_o,
  output logic col_test_o
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (SRST_LEN < 1 || SRST_LEN > 255)
  begin : g_bad_len
    $error("SRST_LEN must lie in 1..255");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Reset value of the control word for a given strap level
  function automatic logic [15:0] ctrl_default(input logic strap);
    logic [15:0] v;
    v = pbm_pkg::CTRL_RESET;
    v[pbm_pkg::CTRL_SPEED_BIT] = strap;
    v[pbm_pkg::CTRL_AN_EN_BIT] = strap;
    return v;
  endfunction

  // Index match for a request
  function automatic logic idx_is(input logic [4:0] idx, input logic [4:0] want);
    return idx == want;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  pbm_pkg::pbm_state_t state_q;
  pbm_pkg::pbm_state_t state_d;
  logic [7:0] srst_cnt_q;
  logic [7:0] srst_cnt_d;
  logic init_q;
  logic strap_q;
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic restart_q;
  logic restart_d;

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  logic idle_w;
  logic wr_ctrl_w;
  logic srst_req_w;
  logic ctrl_wr_w;
  logic rd_stat_w;
  logic in_srst_w;
  logic srst_last_w;

  // Writes are refused until the strap is taken and while in soft reset
  assign idle_w = (state_q == pbm_pkg::PBM_IDLE) && init_q;
  assign wr_ctrl_w = acc_req_i && acc_wr_i && idx_is(acc_idx_i, pbm_pkg::IDX_CTRL);
  assign srst_req_w = wr_ctrl_w && idle_w && acc_wdata_i[pbm_pkg::CTRL_SRST_BIT];
  // Other bits of a reset write are dropped, as software is told
  assign ctrl_wr_w = wr_ctrl_w && idle_w && !acc_wdata_i[pbm_pkg::CTRL_SRST_BIT];
  assign rd_stat_w = acc_req_i && !acc_wr_i && idx_is(acc_idx_i, pbm_pkg::IDX_STAT);
  assign in_srst_w = (state_q == pbm_pkg::PBM_SRST);
  assign srst_last_w = in_srst_w && (srst_cnt_q == 8'h01);

  // ---------------------------------------------------------------
  // Soft reset sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    srst_cnt_d = srst_cnt_q;
    case (state_q)
      pbm_pkg::PBM_IDLE:
      begin
        if (srst_req_w)
        begin
          state_d = pbm_pkg::PBM_SRST;
          srst_cnt_d = 8'(SRST_LEN);
        end
      end
      pbm_pkg::PBM_SRST:
      begin
        srst_cnt_d = srst_cnt_q - 8'h01;
        if (srst_last_w)
          state_d = pbm_pkg::PBM_IDLE;
      end
      default:
      begin
        state_d = pbm_pkg::PBM_IDLE;
        srst_cnt_d = 8'h00;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Control word next value
  // ---------------------------------------------------------------
  always_comb
  begin
    ctrl_d = ctrl_q;
    restart_d = 1'b0;
    if (!init_q)
      ctrl_d = ctrl_default(speed_strap_i);
    else if (srst_req_w)
      // Soft reset restores defaults except the kept fields
      ctrl_d = (ctrl_q & pbm_pkg::CTRL_KEEP_MASK)
             | (ctrl_default(strap_q) & ~pbm_pkg::CTRL_KEEP_MASK);
    else if (ctrl_wr_w)
    begin
      ctrl_d = acc_wdata_i & pbm_pkg::CTRL_RW_MASK;
      restart_d = acc_wdata_i[pbm_pkg::CTRL_RESTART_BIT];
    end
    // Restart is a one-cycle request, never held
    ctrl_d[pbm_pkg::CTRL_RESTART_BIT] = restart_d;
  end

  // Sequencer and control flops
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= pbm_pkg::PBM_IDLE;
      srst_cnt_q <= 8'h00;
      init_q <= 1'b0;
      strap_q <= 1'b0;
      ctrl_q <= pbm_pkg::CTRL_RESET;
      restart_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      srst_cnt_q <= srst_cnt_d;
      init_q <= 1'b1;
      ctrl_q <= ctrl_d;
      restart_q <= restart_d;
      // Strap caught once, in the first cycle after release
      if (!init_q)
        strap_q <= speed_strap_i;
    end
  end

  // ---------------------------------------------------------------
  // Latched status cells
  // ---------------------------------------------------------------
  logic rfault_w;
  logic link_w;
  logic jabber_w;

  pbm_latch #(.LATCH_HIGH(1'b1)) u_rfault (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .clr_i(in_srst_w),
    .rd_i(rd_stat_w),
    .cond_i(remote_fault_i),
    .val_o(rfault_w)
  );

  pbm_latch #(.LATCH_HIGH(1'b0)) u_link (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .clr_i(in_srst_w),
    .rd_i(rd_stat_w),
    .cond_i(link_up_i),
    .val_o(link_w)
  );

  pbm_latch #(.LATCH_HIGH(1'b1)) u_jabber (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .clr_i(in_srst_w),
    .rd_i(rd_stat_w),
    .cond_i(jabber_i),
    .val_o(jabber_w)
  );

  // ---------------------------------------------------------------
  // Read data selection
  // ---------------------------------------------------------------
  logic [15:0] ctrl_rd_w;
  logic [15:0] stat_rd_w;
  logic [15:0] rd_sel_w;

  // Reset bit reads one while the soft reset runs
  assign ctrl_rd_w = {in_srst_w, ctrl_q[14:0]};
  // Fixed abilities plus live and latched flags
  assign stat_rd_w = pbm_pkg::STAT_FIXED
                   | (16'(an_complete_i) << pbm_pkg::STAT_AN_DONE_BIT)
                   | (16'(rfault_w) << pbm_pkg::STAT_RFAULT_BIT)
                   | (16'(link_w) << pbm_pkg::STAT_LINK_BIT)
                   | (16'(jabber_w) << pbm_pkg::STAT_JABBER_BIT);
  // Indexes served elsewhere read zero here
  assign rd_sel_w = idx_is(acc_idx_i, pbm_pkg::IDX_CTRL) ? ctrl_rd_w :
                    idx_is(acc_idx_i, pbm_pkg::IDX_STAT) ? stat_rd_w :
                    idx_is(acc_idx_i, pbm_pkg::IDX_ID_HI) ? ID_HI_VALUE : 16'h0000;

  // ---------------------------------------------------------------
  // Outputs, all registered
  // ---------------------------------------------------------------
  // Manual speed and duplex only reach the core with negotiation off
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      acc_done_o <= 1'b0;
      acc_rdata_o <= 16'h0000;
      soft_reset_o <= 1'b0;
      loopback_o <= 1'b0;
      an_enable_o <= 1'b0;
      force_100_o <= 1'b0;
      force_full_o <= 1'b0;
      power_down_o <= 1'b0;
      an_restart_o <= 1'b0;
      col_test_o <= 1'b0;
    end
    else
    begin
      acc_done_o <= acc_req_i;
      acc_rdata_o <= (acc_req_i && !acc_wr_i) ? rd_sel_w : 16'h0000;
      soft_reset_o <= (state_d == pbm_pkg::PBM_SRST);
      loopback_o <= ctrl_q[pbm_pkg::CTRL_LOOP_BIT];
      an_enable_o <= ctrl_q[pbm_pkg::CTRL_AN_EN_BIT];
      force_100_o <= ctrl_q[pbm_pkg::CTRL_SPEED_BIT] && !ctrl_q[pbm_pkg::CTRL_AN_EN_BIT];
      force_full_o <= ctrl_q[pbm_pkg::CTRL_DUPLEX_BIT] && !ctrl_q[pbm_pkg::CTRL_AN_EN_BIT];
      power_down_o <= ctrl_q[pbm_pkg::CTRL_PDOWN_BIT];
      an_restart_o <= restart_q;
      col_test_o <= ctrl_q[pbm_pkg::CTRL_COLTEST_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_srst_run;
    soft_reset_o [*5] ##1 !soft_reset_o;
  endsequence

  property p_answer;
    @(posedge mclk_i) disable iff (!arst_n_i)
    acc_req_i |=> acc_done_o ##1 (!acc_done_o || $past(acc_req_i));
  endproperty
  a_answer: assert property (p_answer)
    else $error("access not answered in one cycle");

  property p_srst;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (srst_req_w && SRST_LEN == 5) |=> s_srst_run;
  endproperty
  a_srst: assert property (p_srst)
    else $error("soft reset length wrong");

  property p_srst_defaults;
    @(posedge mclk_i) disable iff (!arst_n_i)
    $fell(soft_reset_o) |-> (ctrl_q[14] == 1'b0 && ctrl_q[8] == 1'b0 && ctrl_q[7] == 1'b0
                             && ctrl_q[13] == strap_q);
  endproperty
  a_srst_defaults: assert property (p_srst_defaults)
    else $error("soft reset left control fields set");

  property p_strap;
    @(posedge mclk_i) disable iff (!arst_n_i)
    $rose(init_q) |-> (ctrl_q[13] == strap_q && ctrl_q[12] == strap_q);
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap default not applied");

  property p_loop_write;
    @(posedge mclk_i) disable iff (!arst_n_i)
    ctrl_wr_w |=> ##1 (loopback_o == $past(acc_wdata_i[14], 2)
                     && col_test_o == $past(acc_wdata_i[7], 2));
  endproperty
  a_loop_write: assert property (p_loop_write)
    else $error("loopback or collision test not applied");

  property p_restart;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (ctrl_wr_w && acc_wdata_i[9]) |=> ##1 an_restart_o ##1 !an_restart_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart not a single pulse");

  property p_override;
    @(posedge mclk_i) disable iff (!arst_n_i)
    an_enable_o |-> (!force_100_o && !force_full_o);
  endproperty
  a_override: assert property (p_override)
    else $error("manual mode leaks under negotiation");

  property p_status_read;
    @(posedge mclk_i) disable iff (!arst_n_i)
    rd_stat_w |=> (acc_rdata_o[15:11] == 5'h0F && acc_rdata_o[3] && acc_rdata_o[0]
                   && acc_rdata_o[5] == $past(an_complete_i));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status fixed bits wrong");

  property p_id_read;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (acc_req_i && !acc_wr_i && acc_idx_i == 5'h02) |=> (acc_rdata_o == ID_HI_VALUE);
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identifier read wrong");

  property p_pdown;
    @(posedge mclk_i) disable iff (!arst_n_i)
    ctrl_wr_w |=> ##1 (power_down_o == $past(acc_wdata_i[11], 2));
  endproperty
  a_pdown: assert property (p_pdown)
    else $error("power down not applied");

endmodule

//--- pbm_mac_model.sv
// MAC-side access logic: issues one register access per call of its access task
module pbm_mac_model (
  // Clock
  input wire logic mclk_i,
  // Access request toward the register bank
  output logic acc_req_o,
  output logic acc_wr_o,
  output logic [4:0] acc_idx_o,
  output logic [15:0] acc_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  bit held = 1'b0;

  // Idle bus at time zero
  initial
  begin
    acc_req_o = 1'b0;
    acc_wr_o = 1'b0;
    acc_idx_o = 5'h1F;
    acc_wdata_o = 16'hFFFF;
  end

  // One access; keep leaves the request up so the next one follows back to back
  task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] data,
                        input bit keep, input int gap);
    if (!held)
    begin
      repeat (gap) @(posedge mclk_i);
      @(posedge mclk_i);
    end
    acc_req_o <= 1'b1;
    acc_wr_o <= wr;
    acc_idx_o <= idx;
    acc_wdata_o <= data;
    @(posedge mclk_i);
    held = keep;
    // Released lines show the inverse so stale values cannot pass for good ones
    if (!keep)
    begin
      acc_req_o <= 1'b0;
      acc_wr_o <= ~wr;
      acc_idx_o <= ~idx;
      acc_wdata_o <= ~data;
    end
  endtask
endmodule

//--- phy_basic_mgmt_registers_tb_top.sv
module phy_basic_mgmt_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Setup
  // ------------------------------------------------------------
  localparam int SRST_LEN = 5;
  localparam logic [15:0] ID_HI = 16'hA5C3; // Arbitrary value
  localparam logic [15:0] STAT_BASE = 16'h7809;

  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic speed_strap_i = 1'b0;
  logic link_up_i = 1'b1;
  logic remote_fault_i = 1'b0;
  logic jabber_i = 1'b0;
  logic an_complete_i = 1'b0;
  logic acc_req, acc_wr, acc_done_o;
  logic [4:0] acc_idx;
  logic [15:0] acc_wdata, acc_rdata_o, ctrl_def;
  logic soft_reset_o, loopback_o, an_enable_o, force_100_o, force_full_o;
  logic power_down_o, an_restart_o, col_test_o, strap;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int srst_seen = 0;
  logic [15:0] exp_q[$];
  logic [4:0] idx_list [12] = '{5'd3, 5'd4, 5'd5, 5'd6, 5'd7, 5'd16,
                                5'd17, 5'd18, 5'd27, 5'd29, 5'd30, 5'd31};

  always #20 mclk_i = ~mclk_i;

  pbm_mac_model mac (.mclk_i(mclk_i), .acc_req_o(acc_req), .acc_wr_o(acc_wr),
    .acc_idx_o(acc_idx), .acc_wdata_o(acc_wdata));

  pbm_regs #(.ID_HI_VALUE(ID_HI), .SRST_LEN(SRST_LEN)) dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .acc_req_i(acc_req), .acc_wr_i(acc_wr),
    .acc_idx_i(acc_idx), .acc_wdata_i(acc_wdata), .acc_done_o(acc_done_o),
    .acc_rdata_o(acc_rdata_o), .speed_strap_i(speed_strap_i), .link_up_i(link_up_i),
    .remote_fault_i(remote_fault_i), .jabber_i(jabber_i), .an_complete_i(an_complete_i),
    .soft_reset_o(soft_reset_o), .loopback_o(loopback_o), .an_enable_o(an_enable_o),
    .force_100_o(force_100_o), .force_full_o(force_full_o), .power_down_o(power_down_o),
    .an_restart_o(an_restart_o), .col_test_o(col_test_o));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Note the answer first, then let the MAC model carry the access
  task automatic xfer(input logic w, input logic [4:0] idx, input logic [15:0] data,
                      input logic [15:0] exp, input bit keep);
    exp_q.push_back(exp);
    mac.access(w, idx, data, keep, $urandom_range(2, 0));
  endtask

  // Mode outputs derived from a control word; manual bits lose to negotiation
  task automatic chk_modes(input logic [15:0] c);
    chk("mode_outputs", {10'h000, c[14], c[12], c[13] & ~c[12], c[8] & ~c[12], c[11], c[7]},
        {10'h000, loopback_o, an_enable_o, force_100_o, force_full_o, power_down_o,
         col_test_o});
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Monitor and watchdog
  // ------------------------------------------------------------
  // Mid-cycle sampling keeps clear of the edge that updates the answer
  always @(negedge mclk_i)
  begin
    if (acc_done_o === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        errors++;
        $display("wrong value acc_done_o expected 0 seen 1");
      end
      else
        chk("acc_rdata_o", exp_q.pop_front(), acc_rdata_o);
    end
    if (soft_reset_o === 1'b1)
      srst_seen++;
  end

  // Whole run needs a few hundred cycles; a hang stops here
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      $display("wrong value cycle_budget expected 0 seen 3000");
      summarize();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [15:0] d;
    void'($urandom(5738));
    strap = 1'($urandom_range(1, 0));
    speed_strap_i <= strap;
    repeat (20) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    ctrl_def = {2'b00, strap, strap, 12'h000};

    xfer(1'b0, pbm_pkg::IDX_CTRL, 16'h0000, ctrl_def, 1'b0);
    xfer(1'b0, pbm_pkg::IDX_STAT, 16'h0000, STAT_BASE, 1'b1);
    xfer(1'b0, pbm_pkg::IDX_STAT, 16'h0000, STAT_BASE | 16'h0004, 1'b0);
    repeat (2) @(negedge mclk_i);
    chk_modes(ctrl_def);
    $display("test reset values done");

    xfer(1'b0, pbm_pkg::IDX_ID_HI, 16'h0000, ID_HI, 1'b0);
    xfer(1'b1, pbm_pkg::IDX_ID_HI, ~ID_HI, 16'h0000, 1'b1);
    xfer(1'b0, pbm_pkg::IDX_ID_HI, 16'h0000, ID_HI, 1'b0);
    xfer(1'b1, pbm_pkg::IDX_STAT, 16'h0000, 16'h0000, 1'b0);
    xfer(1'b0, pbm_pkg::IDX_STAT, 16'h0000, STAT_BASE | 16'h0004, 1'b0);
    foreach (idx_list[i])
    begin
      xfer(1'b1, idx_list[i], 16'hFFFF, 16'h0000, 1'b1);
      xfer(1'b0, idx_list[i], 16'h0000, 16'h0000, 1'b0);
    end
    $display("test index map done");

    // Random control words; first two force the negotiation override both ways
    for (int i = 0; i < 8; i++)
    begin
      d = 16'($urandom()) & 16'h7DFF;
      if (i < 2)
        d = (d & 16'hEFFF) | 16'h2100 | (i == 1 ? 16'h1000 : 16'h0000);
      xfer(1'b1, pbm_pkg::IDX_CTRL, d, 16'h0000, 1'b1);
      xfer(1'b0, pbm_pkg::IDX_CTRL, 16'h0000, d & 16'h7980, 1'b0);
      repeat (2) @(negedge mclk_i);
      chk_modes(d);
    end
    $display("test control fields done");

    xfer(1'b1, pbm_pkg::IDX_CTRL, 16'h1200, 16'h0000, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      @(negedge mclk_i);
      chk("an_restart_o", 16'(k == 1), 16'(an_restart_o));
    end
    xfer(1'b0, pbm_pkg::IDX_CTRL, 16'h0000, 16'h1000, 1'b0);
    $display("test restart done");

    xfer(1'b1, pbm_pkg::IDX_CTRL, 16'h4180, 16'h0000, 1'b0);
    srst_seen = 0;
    xfer(1'b1, pbm_pkg::IDX_CTRL, 16'hC180, 16'h0000, 1'b1);
    xfer(1'b0, pbm_pkg::IDX_CTRL, 16'h0000, 16'h8000 | ctrl_def, 1'b0);
    repeat (12) @(negedge mclk_i);
    chk("soft_reset_cycles", 16'(SRST_LEN), 16'(srst_seen));
    xfer(1'b0, pbm_pkg::IDX_CTRL, 16'h0000, ctrl_def, 1'b0);
    xfer(1'b0, pbm_pkg::IDX_STAT, 16'h0000, STAT_BASE, 1'b0);
    repeat (2) @(negedge mclk_i);
    chk_modes(ctrl_def);
    $display("test soft reset done");

    // Short events, gone before the read: latches must still show them
    @(posedge mclk_i);
    remote_fault_i <= 1'b1;
    jabber_i <= 1'b1;
    link_up_i <= 1'b0;
    an_complete_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    remote_fault_i <= 1'b0;
    jabber_i <= 1'b0;
    link_up_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    xfer(1'b0, pbm_pkg::IDX_STAT, 16'h0000, STAT_BASE | 16'h0032, 1'b1);
    xfer(1'b0, pbm_pkg::IDX_STAT, 16'h0000, STAT_BASE | 16'h0024, 1'b0);
    an_complete_i <= 1'b0;
    xfer(1'b0, pbm_pkg::IDX_STAT, 16'h0000, STAT_BASE | 16'h0004, 1'b0);
    $display("test latched status done");

    // Second power-up with the other strap level; link latch must restart low
    @(posedge mclk_i);
    arst_n_i <= 1'b0;
    speed_strap_i <= ~strap;
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    ctrl_def = {2'b00, ~strap, ~strap, 12'h000};
    xfer(1'b0, pbm_pkg::IDX_CTRL, 16'h0000, ctrl_def, 1'b0);
    xfer(1'b0, pbm_pkg::IDX_STAT, 16'h0000, STAT_BASE, 1'b0);
    repeat (2) @(negedge mclk_i);
    chk_modes(ctrl_def);
    $display("test strap at second reset done");

    repeat (4) @(negedge mclk_i);
    chk("pending_answers", 16'h0000, 16'(exp_q.size()));
    summarize();
  end
endmodule
